// ==== common/dcfd_pkg.sv ====
// dcfd_pkg: addresses, field positions, erased values and decode tables of the configuration fuse decoder
// assumes a single clock domain; the table port carries 24-bit program addresses
package dcfd_pkg;
    // configuration space and register addresses
    localparam logic [23:0] CFG_SPACE_LO = 24'h800000;
    localparam logic [23:0] CFG_SPACE_HI = 24'hFFFFFF;
    localparam logic [23:0] CFG_BASE = 24'hF80000;
    localparam int NUM_CFG = 8;
    localparam logic [2:0] IDX_BOOT = 3'h0;
    localparam logic [2:0] IDX_SECURE = 3'h1;
    localparam logic [2:0] IDX_GENERAL = 3'h2;
    localparam logic [2:0] IDX_OSC_SRC = 3'h3;
    localparam logic [2:0] IDX_OSC_MODE = 3'h4;
    localparam logic [2:0] IDX_WATCHDOG = 3'h5;
    localparam logic [2:0] IDX_POR_TIMER = 3'h6;
    localparam logic [2:0] IDX_DEBUG = 3'h7;
    // erased byte and the fixed-one (reserved) mask of the power-on timer register
    localparam logic [7:0] ERASED = 8'hFF;
    localparam logic [7:0] FIXED_ONE_POR = 8'hE0;
    // implemented bit masks; unimplemented bits read as zero
    localparam logic [7:0] MASK_BOOT = 8'hCF;
    localparam logic [7:0] MASK_SECURE = 8'hCF;
    localparam logic [7:0] MASK_GENERAL = 8'h07;
    localparam logic [7:0] MASK_OSC_SRC = 8'h87;
    localparam logic [7:0] MASK_OSC_MODE = 8'hE7;
    localparam logic [7:0] MASK_WATCHDOG = 8'hDF;
    localparam logic [7:0] MASK_POR_TIMER = 8'hF7;
    localparam logic [7:0] MASK_DEBUG = 8'hE3;
    // segment end addresses
    localparam logic [23:0] SEG_END_1K = 24'h0007FE;
    localparam logic [23:0] SEG_END_4K = 24'h001FFE;
    localparam logic [23:0] SEG_END_8K = 24'h003FFE;
    localparam logic [23:0] SEG_END_16K = 24'h007FFE;
    // ram protection sizes in bytes
    localparam logic [12:0] RAM_128 = 13'h0080;
    localparam logic [12:0] RAM_256 = 13'h0100;
    localparam logic [12:0] RAM_1024 = 13'h0400;
    localparam logic [12:0] RAM_4096 = 13'h1000;
    // security levels
    typedef enum logic [1:0] {SEC_NONE = 2'h0, SEC_STANDARD = 2'h1, SEC_HIGH = 2'h2} dcfd_sec_t;
    // watchdog prescale ratios
    localparam logic [7:0] WDT_PRE_128 = 8'h80;
    localparam logic [7:0] WDT_PRE_32 = 8'h20;
    // power-on timer: 2 ms base figure and the clock rate
    localparam int POR_BASE_MS = 2;
    localparam int CLK_HZ = 25000000;
    localparam int POR_BASE_CYCLES = POR_BASE_MS * (CLK_HZ / 1000);
    // oscillator source codes
    localparam logic [2:0] OSC_FRC_POST = 3'h7;
    localparam logic [2:0] OSC_FRC_DIV16 = 3'h6;
    localparam logic [2:0] OSC_LOW_POWER_INTERNAL_RC = 3'h5;
    localparam logic [2:0] OSC_SECONDARY = 3'h4;
    localparam logic [2:0] OSC_PRI_PLL = 3'h3;
    localparam logic [2:0] OSC_PRIMARY = 3'h2;
    localparam logic [2:0] OSC_FRC_PLL = 3'h1;
    localparam logic [2:0] OSC_FRC = 3'h0;
    // primary oscillator modes
    localparam logic [1:0] PMODE_OFF = 2'h3;
    localparam logic [1:0] PMODE_HS = 2'h2;
    localparam logic [1:0] PMODE_XT = 2'h1;
    localparam logic [1:0] PMODE_EC = 2'h0;
endpackage : dcfd_pkg

// ==== rtl/dcfd_fuse_byte.sv ====
// dcfd_fuse_byte: one configuration byte with write-once-per-power-cycle bits
// assumes power_rst is the power-on reset only; device resets do not clear the lock
`timescale 1ns/100ps
module dcfd_fuse_byte #(
    parameter logic [7:0] IMPL_MASK = 8'hFF,
    parameter logic [7:0] FIXED_ONE = 8'h00
) (
    // clock and power-on reset
    input wire logic clk,
    input wire logic power_rst,
    // table write strobe and data
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    // stored value
    output logic [7:0] value
);
    import dcfd_pkg::*;

    // state: the byte and a per-bit written flag
    typedef struct packed {
        logic [7:0] bits_reg;
        logic [7:0] done_reg;
    } dcfd_fb_state_t;

    dcfd_fb_state_t st_reg;
    dcfd_fb_state_t st_next;

    // each bit takes the first write only; later writes this power cycle are dropped
    always_comb begin
        st_next = st_reg;
        if (wr_en) begin
            st_next.bits_reg = (st_reg.bits_reg & st_reg.done_reg) | (wr_data & ~st_reg.done_reg);
            st_next.done_reg = 8'hFF;
        end
    end

    // erased state presents all ones
    always_ff @(posedge clk or posedge power_rst) begin
        if (power_rst) begin
            st_reg <= '{bits_reg: ERASED, done_reg: 8'h00};
        end else begin
            st_reg <= st_next;
        end
    end

    // reserved bits read one, unimplemented bits read zero
    assign value = (st_reg.bits_reg | FIXED_ONE) & IMPL_MASK;

    written_once_a: assert property (@(posedge clk) disable iff (power_rst)
        $past(st_reg.done_reg[0]) |-> st_reg.bits_reg[0] == $past(st_reg.bits_reg[0]))
        else $error("fuse bit changed after first write");
endmodule : dcfd_fuse_byte

// ==== rtl/dcfd_fuse_decoder.sv ====
// dcfd_fuse_decoder: configuration bytes behind a table read/write port, decoded into device settings
// assumes POWER_RESET marks power cycles, RESET marks device resets; table strobes are synchronous
//
// Operation
// - programmed bit reads 0, erased reads 1
// - bytes at 0xF80000, table access only
// - each bit writable once per power cycle
// - boot segment size, security, write protect decode
// - boot RAM size decode 128/256/1024
// - secure segment size, security, write protect decode
// - secure RAM size decode, minus boot RAM
// - general segment code and write protect
// - two-speed start on fast RC, then switch
// - initial oscillator source, eight choices
// - clock switching and fail-safe monitor modes
// - pin remap lock allows one reconfiguration
// - second osc pin clock out or GPIO
// - primary oscillator mode decode
// - watchdog always on overrides software enable
// - watchdog window bit: 1 non-window, 0 windowed
// - watchdog prescaler 128 when set, 32 cleared
// - watchdog postscaler top codes 32768 and 16384
// - power-on timer 2..128 ms, 000 disabled
// - two-wire bus primary or alternate pins
// - test access port enable bit
// - debug channel pin pair select
// - lowest postscaler code gives 1:1
`timescale 1ns/100ps
module dcfd_fuse_decoder #(
    parameter int POR_BASE_CYCLES = dcfd_pkg::POR_BASE_CYCLES
) (
    // clock and resets
    input wire logic SYS_CLK,
    input wire logic RESET,
    input wire logic POWER_RESET,
    // table access port
    input wire logic TBL_RD,
    input wire logic TBL_WR,
    input wire logic [23:0] TBL_ADDR,
    input wire logic [7:0] TBL_WDATA,
    output logic [7:0] TBL_RDATA,
    output logic TBL_RVALID,
    output logic TBL_HIT,
    // runtime inputs
    input wire logic SOFT_WATCHDOG_ENABLE,
    input wire logic SELECTED_OSC_READY,
    input wire logic [2:0] REMAP_COUNT_IN,
    // boot segment
    output logic [23:0] BOOT_SEGMENT_END,
    output dcfd_pkg::dcfd_sec_t BOOT_SECURITY,
    output logic BOOT_WRITE_PROTECTED,
    output logic [12:0] BOOT_RAM_BYTES,
    // secure segment
    output logic [23:0] SECURE_SEGMENT_END,
    output dcfd_pkg::dcfd_sec_t SECURE_SECURITY,
    output logic SECURE_WRITE_PROTECTED,
    output logic [12:0] SECURE_RAM_BYTES,
    // general segment
    output dcfd_pkg::dcfd_sec_t GENERAL_SECURITY,
    output logic GENERAL_WRITE_PROTECTED,
    // oscillator
    output logic [2:0] ACTIVE_OSC_SOURCE,
    output logic [2:0] INITIAL_OSC_SOURCE,
    output logic TWO_SPEED_ACTIVE,
    output logic CLOCK_SWITCH_ENABLE,
    output logic FAIL_SAFE_MONITOR_ENABLE,
    output logic [1:0] PRIMARY_OSC_MODE,
    output logic SECOND_OSC_PIN_CLKOUT,
    output logic SECOND_OSC_PIN_GPIO,
    output logic PIN_REMAP_ALLOWED,
    // watchdog
    output logic WATCHDOG_RUN,
    output logic WATCHDOG_WINDOWED,
    output logic [7:0] WATCHDOG_PRESCALE,
    output logic [15:0] WATCHDOG_POSTSCALE_M1,
    // power-on timer, buses, debug
    output logic POWER_ON_TIMER_BUSY,
    output logic ALT_TWO_WIRE_PINS,
    output logic TEST_PORT_ENABLE,
    output logic [1:0] DEBUG_CHANNEL_PAIR,
    output logic DEBUG_CHANNEL_RESERVED
);
    import dcfd_pkg::*;

    // per-byte implemented and fixed masks, indexed by register number
    localparam logic [7:0] IMPL_MASKS [NUM_CFG] = '{MASK_BOOT, MASK_SECURE, MASK_GENERAL, MASK_OSC_SRC,
        MASK_OSC_MODE, MASK_WATCHDOG, MASK_POR_TIMER, MASK_DEBUG};
    localparam logic [7:0] FIXED_MASKS [NUM_CFG] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        FIXED_ONE_POR, 8'h00};

    // decoded settings snapshot
    typedef struct packed {
        logic [7:0] rdata_reg;
        logic rvalid_reg;
        logic hit_reg;
        logic [23:0] boot_end_reg;
        dcfd_sec_t boot_sec_reg;
        logic boot_wp_reg;
        logic [12:0] boot_ram_reg;
        logic [23:0] sec_end_reg;
        dcfd_sec_t sec_sec_reg;
        logic sec_wp_reg;
        logic [12:0] sec_ram_reg;
        dcfd_sec_t gen_sec_reg;
        logic gen_wp_reg;
        logic [2:0] init_osc_reg;
        logic [2:0] act_osc_reg;
        logic two_speed_reg;
        logic two_speed_on_reg;
        logic sw_en_reg;
        logic fscm_reg;
        logic [1:0] pmode_reg;
        logic clkout_reg;
        logic gpio_reg;
        logic remap_once_reg;
        logic remap_ok_reg;
        logic wdt_always_reg;
        logic wdt_run_reg;
        logic wdt_win_reg;
        logic [7:0] wdt_pre_reg;
        logic [15:0] wdt_post_reg;
        logic [2:0] por_code_reg;
        logic alt_bus_reg;
        logic test_en_reg;
        logic [1:0] dbg_pair_reg;
        logic dbg_rsvd_reg;
        logic start_reg;
    } dcfd_state_t;

    dcfd_state_t st_reg;
    dcfd_state_t st_next;

    // byte storage and address decode
    logic [7:0] cfg [NUM_CFG];
    logic in_cfg_space;
    logic in_map;
    logic [2:0] idx;
    logic timer_busy;

    // configuration space is reached only through this table port
    assign in_cfg_space = (TBL_ADDR >= CFG_SPACE_LO) && (TBL_ADDR <= CFG_SPACE_HI);
    assign in_map = in_cfg_space && (TBL_ADDR[23:4] == CFG_BASE[23:4]) && !TBL_ADDR[0];
    assign idx = TBL_ADDR[3:1];

    // one write-once byte per register
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CFG; gi++) begin : g_byte
            dcfd_fuse_byte #(
                .IMPL_MASK(IMPL_MASKS[gi]),
                .FIXED_ONE(FIXED_MASKS[gi])
            ) u_byte (
                .clk(SYS_CLK),
                .power_rst(POWER_RESET),
                .wr_en(TBL_WR && in_map && idx == 3'(gi)),
                .wr_data(TBL_WDATA),
                .value(cfg[gi])
            );
        end
    endgenerate

    // power-on delay after device reset release
    dcfd_por_timer #(
        .BASE_CYCLES(POR_BASE_CYCLES)
    ) u_por (
        .clk(SYS_CLK),
        .rst(RESET),
        .start(st_reg.start_reg),
        .code(cfg[IDX_POR_TIMER][2:0]),
        .busy(timer_busy)
    );

    // next-state: table read answers, decode captured only in the cycle after reset release
    always_comb begin
        st_next = st_reg;
        st_next.start_reg = 1'b0;
        // table read: one-cycle answer, unmapped config space reads zero
        st_next.rvalid_reg = TBL_RD;
        st_next.hit_reg = TBL_RD && in_map;
        if (TBL_RD && in_map) begin
            st_next.rdata_reg = cfg[idx];
        end else if (TBL_RD) begin
            st_next.rdata_reg = 8'h00;
        end
        if (st_reg.start_reg) begin
            // boot segment
            case (cfg[IDX_BOOT][2:1])
                2'h3: st_next.boot_end_reg = 24'h000000;
                2'h2: st_next.boot_end_reg = SEG_END_1K;
                2'h1: st_next.boot_end_reg = SEG_END_4K;
                default: st_next.boot_end_reg = SEG_END_8K;
            endcase
            st_next.boot_sec_reg = (cfg[IDX_BOOT][2:1] == 2'h3) ? SEC_NONE :
                (cfg[IDX_BOOT][3] ? SEC_STANDARD : SEC_HIGH);
            st_next.boot_wp_reg = !cfg[IDX_BOOT][0];
            case (cfg[IDX_BOOT][7:6])
                2'h3: st_next.boot_ram_reg = 13'h0000;
                2'h2: st_next.boot_ram_reg = RAM_128;
                2'h1: st_next.boot_ram_reg = RAM_256;
                default: st_next.boot_ram_reg = RAM_1024;
            endcase
            // secure segment
            case (cfg[IDX_SECURE][2:1])
                2'h3: st_next.sec_end_reg = 24'h000000;
                2'h2: st_next.sec_end_reg = SEG_END_4K;
                2'h1: st_next.sec_end_reg = SEG_END_8K;
                default: st_next.sec_end_reg = SEG_END_16K;
            endcase
            st_next.sec_sec_reg = (cfg[IDX_SECURE][2:1] == 2'h3) ? SEC_NONE :
                (cfg[IDX_SECURE][3] ? SEC_STANDARD : SEC_HIGH);
            st_next.sec_wp_reg = !cfg[IDX_SECURE][0];
            // secure ram is the size less the boot ram; code 01 taken as 2048
            case (cfg[IDX_SECURE][7:6])
                2'h3: st_next.sec_ram_reg = 13'h0000;
                2'h2: st_next.sec_ram_reg = RAM_256 - st_next.boot_ram_reg;
                2'h1: st_next.sec_ram_reg = 13'h0800 - st_next.boot_ram_reg;
                default: st_next.sec_ram_reg = RAM_4096 - st_next.boot_ram_reg;
            endcase
            // general segment
            case (cfg[IDX_GENERAL][2:1])
                2'h3: st_next.gen_sec_reg = SEC_NONE;
                2'h2: st_next.gen_sec_reg = SEC_STANDARD;
                default: st_next.gen_sec_reg = SEC_HIGH;
            endcase
            st_next.gen_wp_reg = !cfg[IDX_GENERAL][0];
            // oscillator source
            st_next.init_osc_reg = cfg[IDX_OSC_SRC][2:0];
            st_next.two_speed_reg = cfg[IDX_OSC_SRC][7];
            st_next.two_speed_on_reg = cfg[IDX_OSC_SRC][7];
            st_next.act_osc_reg = cfg[IDX_OSC_SRC][7] ? OSC_FRC : cfg[IDX_OSC_SRC][2:0];
            // oscillator mode
            st_next.sw_en_reg = !cfg[IDX_OSC_MODE][7];
            st_next.fscm_reg = (cfg[IDX_OSC_MODE][7:6] == 2'h0);
            st_next.remap_once_reg = cfg[IDX_OSC_MODE][5];
            st_next.pmode_reg = cfg[IDX_OSC_MODE][1:0];
            // second pin only free when not a crystal mode
            if (cfg[IDX_OSC_MODE][1:0] == PMODE_HS || cfg[IDX_OSC_MODE][1:0] == PMODE_XT) begin
                st_next.clkout_reg = 1'b0;
                st_next.gpio_reg = 1'b0;
            end else begin
                st_next.clkout_reg = cfg[IDX_OSC_MODE][2];
                st_next.gpio_reg = !cfg[IDX_OSC_MODE][2];
            end
            // watchdog
            st_next.wdt_always_reg = cfg[IDX_WATCHDOG][7];
            st_next.wdt_win_reg = !cfg[IDX_WATCHDOG][6];
            st_next.wdt_pre_reg = cfg[IDX_WATCHDOG][4] ? WDT_PRE_128 : WDT_PRE_32;
            st_next.wdt_post_reg = (16'h0001 << cfg[IDX_WATCHDOG][3:0]) - 16'h0001;
            // power-on timer, buses, debug
            st_next.por_code_reg = cfg[IDX_POR_TIMER][2:0];
            st_next.alt_bus_reg = !cfg[IDX_POR_TIMER][4];
            st_next.test_en_reg = cfg[IDX_DEBUG][5];
            st_next.dbg_pair_reg = 2'h3 - cfg[IDX_DEBUG][1:0];
            st_next.dbg_rsvd_reg = (cfg[IDX_DEBUG][1:0] == 2'h0);
        end
        // two-speed start hands over once the selected source is ready
        if (st_reg.two_speed_on_reg && SELECTED_OSC_READY && !st_reg.start_reg) begin
            st_next.two_speed_on_reg = 1'b0;
            st_next.act_osc_reg = st_reg.init_osc_reg;
        end
        // watchdog forced on, or left to software
        st_next.wdt_run_reg = st_reg.wdt_always_reg || SOFT_WATCHDOG_ENABLE;
        // remap lock: after one reconfiguration no more are allowed
        st_next.remap_ok_reg = !st_reg.remap_once_reg || (REMAP_COUNT_IN == 3'h0);
    end

    // device reset clears the snapshot; it is refilled on release and held until next reset, except the read answer, osc handover, watchdog run and remap flags
    always_ff @(posedge SYS_CLK or posedge RESET) begin
        if (RESET) begin
            st_reg <= '0;
            st_reg.start_reg <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs straight from flip-flops
    assign TBL_RDATA = st_reg.rdata_reg;
    assign TBL_RVALID = st_reg.rvalid_reg;
    assign TBL_HIT = st_reg.hit_reg;
    assign BOOT_SEGMENT_END = st_reg.boot_end_reg;
    assign BOOT_SECURITY = st_reg.boot_sec_reg;
    assign BOOT_WRITE_PROTECTED = st_reg.boot_wp_reg;
    assign BOOT_RAM_BYTES = st_reg.boot_ram_reg;
    assign SECURE_SEGMENT_END = st_reg.sec_end_reg;
    assign SECURE_SECURITY = st_reg.sec_sec_reg;
    assign SECURE_WRITE_PROTECTED = st_reg.sec_wp_reg;
    assign SECURE_RAM_BYTES = st_reg.sec_ram_reg;
    assign GENERAL_SECURITY = st_reg.gen_sec_reg;
    assign GENERAL_WRITE_PROTECTED = st_reg.gen_wp_reg;
    assign ACTIVE_OSC_SOURCE = st_reg.act_osc_reg;
    assign INITIAL_OSC_SOURCE = st_reg.init_osc_reg;
    assign TWO_SPEED_ACTIVE = st_reg.two_speed_on_reg;
    assign CLOCK_SWITCH_ENABLE = st_reg.sw_en_reg;
    assign FAIL_SAFE_MONITOR_ENABLE = st_reg.fscm_reg;
    assign PRIMARY_OSC_MODE = st_reg.pmode_reg;
    assign SECOND_OSC_PIN_CLKOUT = st_reg.clkout_reg;
    assign SECOND_OSC_PIN_GPIO = st_reg.gpio_reg;
    assign PIN_REMAP_ALLOWED = st_reg.remap_ok_reg;
    assign WATCHDOG_RUN = st_reg.wdt_run_reg;
    assign WATCHDOG_WINDOWED = st_reg.wdt_win_reg;
    assign WATCHDOG_PRESCALE = st_reg.wdt_pre_reg;
    assign WATCHDOG_POSTSCALE_M1 = st_reg.wdt_post_reg;
    assign POWER_ON_TIMER_BUSY = timer_busy;
    assign ALT_TWO_WIRE_PINS = st_reg.alt_bus_reg;
    assign TEST_PORT_ENABLE = st_reg.test_en_reg;
    assign DEBUG_CHANNEL_PAIR = st_reg.dbg_pair_reg;
    assign DEBUG_CHANNEL_RESERVED = st_reg.dbg_rsvd_reg;

    // checks
    read_erased_a: assert property (@(posedge SYS_CLK) disable iff (RESET || POWER_RESET)
        TBL_RD && !TBL_WR && in_map && cfg[idx] == IMPL_MASKS[idx] |=> TBL_RDATA == IMPL_MASKS[$past(idx)])
        else $error("erased byte did not read back as ones");
    outside_space_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        TBL_RD && !in_cfg_space |=> !TBL_HIT && TBL_RDATA == 8'h00)
        else $error("read outside configuration space hit a byte");
    settings_held_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        !st_reg.start_reg && !$past(st_reg.start_reg) |-> $stable(BOOT_SEGMENT_END) && $stable(WATCHDOG_PRESCALE))
        else $error("settings changed outside device reset");
    boot_none_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        st_reg.start_reg && cfg[IDX_BOOT][2:1] == 2'h3 |=> BOOT_SEGMENT_END == 24'h000000 && BOOT_SECURITY == SEC_NONE)
        else $error("boot segment not empty for x11");
    two_speed_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        st_reg.start_reg && cfg[IDX_OSC_SRC][7] |=> ACTIVE_OSC_SOURCE == OSC_FRC)
        else $error("two-speed start not on fast rc");
    wdt_forced_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        st_reg.wdt_always_reg |=> WATCHDOG_RUN)
        else $error("watchdog stopped while forced on");
    fscm_mode_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        FAIL_SAFE_MONITOR_ENABLE |-> CLOCK_SWITCH_ENABLE)
        else $error("fail-safe monitor without clock switching");
    debug_pair_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        st_reg.start_reg && cfg[IDX_DEBUG][1:0] == 2'h3 |=> DEBUG_CHANNEL_PAIR == 2'h0)
        else $error("debug code 11 not on pair 1");
    post_top_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
        st_reg.start_reg && cfg[IDX_WATCHDOG][3:0] == 4'hF |=> WATCHDOG_POSTSCALE_M1 == 16'h7FFF)
        else $error("postscale 1111 not 32768");
    cover_write_c: cover property (@(posedge SYS_CLK) TBL_WR && in_map);
    cover_switch_c: cover property (@(posedge SYS_CLK) $fell(TWO_SPEED_ACTIVE));
    cover_timer_c: cover property (@(posedge SYS_CLK) $fell(POWER_ON_TIMER_BUSY));
endmodule : dcfd_fuse_decoder

// ==== rtl/dcfd_por_timer.sv ====
// dcfd_por_timer: counts the power-on delay chosen by the timer field
// assumes start is a one-cycle pulse at device reset release
`timescale 1ns/100ps
module dcfd_por_timer #(
    parameter int BASE_CYCLES = dcfd_pkg::POR_BASE_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // start pulse and delay code
    input wire logic start,
    input wire logic [2:0] code,
    // delay still running
    output logic busy
);
    import dcfd_pkg::*;

    typedef struct packed {
        logic [31:0] cnt_reg;
        logic busy_reg;
    } dcfd_pt_state_t;

    dcfd_pt_state_t st_reg;
    dcfd_pt_state_t st_next;

    // code 001 is 2 ms, each step doubles up to 128 ms; 000 means no delay
    always_comb begin
        st_next = st_reg;
        if (start) begin
            if (code == 3'h0) begin
                st_next.busy_reg = 1'b0;
            end else begin
                st_next.cnt_reg = 32'(BASE_CYCLES) << (code - 3'h1);
                st_next.busy_reg = 1'b1;
            end
        end else if (st_reg.busy_reg) begin
            st_next.cnt_reg = st_reg.cnt_reg - 32'h1;
            if (st_reg.cnt_reg <= 32'h1) begin
                st_next.busy_reg = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= '{cnt_reg: 32'h0, busy_reg: 1'b1};
        end else begin
            st_reg <= st_next;
        end
    end

    assign busy = st_reg.busy_reg;

    disabled_timer_a: assert property (@(posedge clk) disable iff (rst)
        start && code == 3'h0 |=> !busy)
        else $error("disabled power-on timer still busy");
endmodule : dcfd_por_timer

// ==== sim/testbench.sv ====
// testbench: table-port reads and writes of the fuse decoder, then decoded settings after a device reset
// assumes power reset and device reset start together; timer base is shortened to 4 cycles
`timescale 1ns/100ps
module testbench;
    import dcfd_pkg::*;
    // clocks, resets and table port
    logic SYS_CLK = 1'b0, RESET = 1'b1, POWER_RESET = 1'b1, TBL_RD = 1'b0, TBL_WR = 1'b0;
    logic [23:0] TBL_ADDR = 24'h000000;
    logic [7:0] TBL_WDATA = 8'h00;
    logic SOFT_WATCHDOG_ENABLE = 1'b1, SELECTED_OSC_READY = 1'b0;
    logic [2:0] REMAP_COUNT_IN = 3'h0;
    // decoded outputs
    logic [7:0] TBL_RDATA, WATCHDOG_PRESCALE;
    logic TBL_RVALID, TBL_HIT, BOOT_WRITE_PROTECTED, SECURE_WRITE_PROTECTED, GENERAL_WRITE_PROTECTED;
    logic [23:0] BOOT_SEGMENT_END, SECURE_SEGMENT_END;
    logic [12:0] BOOT_RAM_BYTES, SECURE_RAM_BYTES;
    dcfd_sec_t BOOT_SECURITY, SECURE_SECURITY, GENERAL_SECURITY;
    logic [2:0] ACTIVE_OSC_SOURCE, INITIAL_OSC_SOURCE;
    logic TWO_SPEED_ACTIVE, CLOCK_SWITCH_ENABLE, FAIL_SAFE_MONITOR_ENABLE, SECOND_OSC_PIN_CLKOUT;
    logic SECOND_OSC_PIN_GPIO, PIN_REMAP_ALLOWED, WATCHDOG_RUN, WATCHDOG_WINDOWED, POWER_ON_TIMER_BUSY;
    logic [1:0] PRIMARY_OSC_MODE, DEBUG_CHANNEL_PAIR;
    logic [15:0] WATCHDOG_POSTSCALE_M1;
    logic ALT_TWO_WIRE_PINS, TEST_PORT_ENABLE, DEBUG_CHANNEL_RESERVED;
    int mismatches = 0, checks_done = 0;
    // design under test with a short timer base
    dcfd_fuse_decoder #(.POR_BASE_CYCLES(4)) dcfd_fuse_decoder_i (.*);
    // free-running 25 MHz clock
    initial begin
        forever #20 SYS_CLK = ~SYS_CLK;
    end
    // compare one value and count it
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // one-cycle table write
    task automatic wr(input logic [23:0] a, input logic [7:0] d);
        @(posedge SYS_CLK) {TBL_WR, TBL_ADDR, TBL_WDATA} <= {1'b1, a, d};
        @(posedge SYS_CLK) TBL_WR <= 1'b0;
    endtask : wr
    // one-cycle table read; answer checked one edge later
    task automatic rd(input logic [23:0] a, input logic [7:0] e, input logic hit);
        @(posedge SYS_CLK) {TBL_RD, TBL_ADDR} <= {1'b1, a};
        @(posedge SYS_CLK) TBL_RD <= 1'b0;
        #1 chk({TBL_RVALID, TBL_HIT, TBL_RDATA}, {1'b1, hit, e});
    endtask : rd
    // device reset pulse; settings recaptured on release
    task automatic dev_reset;
        @(posedge SYS_CLK) RESET <= 1'b1;
        repeat (2) @(posedge SYS_CLK);
        RESET <= 1'b0;
        repeat (3) @(posedge SYS_CLK);
        #1;
    endtask : dev_reset
    // counts, verdict and end of run
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    // hang guard, well past the expected run
    initial begin
        repeat (5000) @(posedge SYS_CLK);
        mismatches++;
        report_and_stop();
    end
    // test sequence
    initial begin
        repeat (5) @(posedge SYS_CLK);
        POWER_RESET <= 1'b0;
        RESET <= 1'b0;
        repeat (3) @(posedge SYS_CLK);
        #1 chk(ACTIVE_OSC_SOURCE, OSC_FRC);
        chk({INITIAL_OSC_SOURCE, CLOCK_SWITCH_ENABLE, FAIL_SAFE_MONITOR_ENABLE}, {OSC_FRC_POST, 2'b00});
        chk({SECURE_SEGMENT_END, SECURE_SECURITY, SECURE_WRITE_PROTECTED}, {24'h000000, SEC_NONE, 1'b0});
        chk({SECURE_RAM_BYTES, GENERAL_SECURITY, GENERAL_WRITE_PROTECTED}, {13'h0000, SEC_NONE, 1'b0});
        chk({PRIMARY_OSC_MODE, SECOND_OSC_PIN_CLKOUT, SECOND_OSC_PIN_GPIO}, {PMODE_OFF, 2'b10});
        chk({TWO_SPEED_ACTIVE, PIN_REMAP_ALLOWED, WATCHDOG_POSTSCALE_M1}, {2'b11, 16'h7FFF});
        @(posedge SYS_CLK) {SELECTED_OSC_READY, REMAP_COUNT_IN} <= {1'b1, 3'h1};
        repeat (2) @(posedge SYS_CLK);
        #1 chk({ACTIVE_OSC_SOURCE, TWO_SPEED_ACTIVE, PIN_REMAP_ALLOWED}, {OSC_FRC_POST, 2'b00});
        repeat (245) @(posedge SYS_CLK);
        #1 chk(POWER_ON_TIMER_BUSY, 1'b1);
        repeat (12) @(posedge SYS_CLK);
        #1 chk(POWER_ON_TIMER_BUSY, 1'b0);
        $display("test erased settings done");
        rd(24'hF80000, 8'hCF, 1'b1);
        rd(24'hF8000C, 8'hF7, 1'b1);
        rd(24'hF80010, 8'h00, 1'b0);
        wr(24'hF80000, 8'hF1);
        wr(24'hF80000, 8'h00);
        rd(24'hF80000, 8'hC1, 1'b1);
        wr(24'hF8000A, 8'h50);
        wr(24'hF8000E, 8'hE1);
        wr(24'hF8000C, 8'hE0);
        wr(24'hF80002, 8'h8D);
        wr(24'hF80004, 8'h02);
        wr(24'hF80008, 8'h40);
        $display("test table access done");
        dev_reset();
        chk({BOOT_SEGMENT_END, BOOT_SECURITY, BOOT_WRITE_PROTECTED}, {SEG_END_8K, SEC_HIGH, 1'b0});
        chk(BOOT_RAM_BYTES, 13'h0000);
        chk({WATCHDOG_RUN, WATCHDOG_WINDOWED, WATCHDOG_PRESCALE}, {2'b10, WDT_PRE_128});
        chk(WATCHDOG_POSTSCALE_M1, 16'h0000);
        chk({TEST_PORT_ENABLE, DEBUG_CHANNEL_PAIR, DEBUG_CHANNEL_RESERVED}, {1'b1, 2'h2, 1'b0});
        chk(ALT_TWO_WIRE_PINS, 1'b1);
        chk({SECURE_SEGMENT_END, SECURE_SECURITY, SECURE_WRITE_PROTECTED}, {SEG_END_4K, SEC_STANDARD, 1'b0});
        chk({SECURE_RAM_BYTES, GENERAL_SECURITY, GENERAL_WRITE_PROTECTED}, {RAM_256, SEC_HIGH, 1'b1});
        chk({CLOCK_SWITCH_ENABLE, FAIL_SAFE_MONITOR_ENABLE, PRIMARY_OSC_MODE}, {2'b10, PMODE_EC});
        chk({SECOND_OSC_PIN_CLKOUT, SECOND_OSC_PIN_GPIO, PIN_REMAP_ALLOWED}, 3'b011);
        #1 chk(POWER_ON_TIMER_BUSY, 1'b0);
        @(posedge SYS_CLK) SOFT_WATCHDOG_ENABLE <= 1'b0;
        repeat (2) @(posedge SYS_CLK);
        #1 chk(WATCHDOG_RUN, 1'b0);
        $display("test decoded settings done");
        report_and_stop();
    end
endmodule : testbench
